// ### trace_state_qualifier.sv
// Trace state qualifier: evaluates captured states for all analyzer consumers.
// Assumes configuration is loaded by the analyzer controller between traces.
//
// Summary of operation
// RL1: One qualifier result per consumer feeds trigger, time, both branches and prestore.
// RL2: Simple form compares a masked label against a value for eq, ne, in range or out.
// RL3: Set one holds patterns one to four, the range result and its complement.
// RL4: Set two holds patterns five to eight and the arm condition.
// RL5: Patterns and the range bounds are loaded through their assign ports.
// RL6: The arm member follows the arm condition input, not a state compare.
// RL7: Each set combines its selected members by OR or NOR.
// RL8: A set uses one operator for all its members.
// RL9: The two set terms join by a final AND or OR.
// RL10: The final join is symmetric in its two terms.
// RL11: Software keeps to one term per set; extra chaining is rejected upstream.
// RL12: The complemented range member is true exactly when the range is false.
// RL13: Fixed always-true and always-false selections bypass all comparators.
// RL14: Results are registered on the sample clock in the cycle the state is stored.
`timescale 1ns/1ps
`include "qualifier_map.svh"
module trace_state_qualifier (
  // Clock and analyzer init
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  // Captured state
  input  wire logic [`QUAL_STATE_W-1:0] state_in,
  input  wire logic                     state_valid_in,
  input  wire logic                     arm_in,
  // Resource loading
  input  wire logic                     pattern_load_in,
  input  wire logic [2:0]               pattern_index_in,
  input  wire qualifier_pkg::pattern_t  pattern_in,
  input  wire logic                     range_load_in,
  input  wire qualifier_pkg::range_t    range_in,
  // Expression loading, one per consumer
  input  wire logic                     expr_load_in,
  input  wire logic [2:0]               expr_index_in,
  input  wire qualifier_pkg::expr_t     expr_in,
  // Simple form operands, shared by all consumers
  input  wire logic [`QUAL_STATE_W-1:0] simple_mask_in,
  input  wire logic [`QUAL_STATE_W-1:0] simple_low_in,
  input  wire logic [`QUAL_STATE_W-1:0] simple_high_in,
  // Results
  output qualifier_pkg::qual_out_t      qual_out,
  output logic                          qual_valid_out
);
  localparam int NC = 5;

  qualifier_pkg::pattern_t pattern_r [`QUAL_PATTERNS];
  qualifier_pkg::range_t   range_r;
  qualifier_pkg::expr_t    expr_r [NC];
  logic [NC-1:0]           result_nxt;
  logic [NC-1:0]           result_r;
  logic                    valid_r;

  // Pattern comparators
  wire [`QUAL_PATTERNS-1:0] pat_hit;
  genvar g;
  generate
    for (g = 0; g < `QUAL_PATTERNS; g++) begin : g_pat
      wire eq = ((state_in ^ pattern_r[g].value) & pattern_r[g].mask) == '0;
      assign pat_hit[g] = eq ^ pattern_r[g].invert; // RL5
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          pattern_r[g] <= '{`QUAL_RESET_VALUE, `QUAL_RESET_MASK, 1'b0};
        end else if (pattern_load_in && pattern_index_in == 3'(g)) begin
          pattern_r[g] <= pattern_in; // RL5
        end
      end
    end
  endgenerate

  // Range comparator, unsigned inclusive
  wire [`QUAL_STATE_W-1:0] ranged = state_in & range_r.mask;
  wire range_hit = (ranged >= range_r.low) && (ranged <= range_r.high);
  wire range_miss = ~range_hit; // RL12

  // Simple form
  wire [`QUAL_STATE_W-1:0] s_lab = state_in & simple_mask_in;
  wire s_eq = s_lab == (simple_low_in & simple_mask_in);
  wire s_in = (s_lab >= simple_low_in) && (s_lab <= simple_high_in);

  wire [5:0] set1_members = {range_miss, range_hit, pat_hit[3:0]}; // RL3
  wire [4:0] set2_members = {arm_in, pat_hit[7:4]}; // RL4 RL6

  generate
    for (g = 0; g < NC; g++) begin : g_expr
      wire t1;
      wire t2;
      wire simple_res;
      wire complex_res;
      set_combiner #(.N(6)) u_set1 (
        .member_in (set1_members),
        .select_in (expr_r[g].set1_sel),
        .nor_in    (expr_r[g].set1_nor),
        .term_out  (t1)
      );
      set_combiner #(.N(5)) u_set2 (
        .member_in (set2_members),
        .select_in (expr_r[g].set2_sel),
        .nor_in    (expr_r[g].set2_nor),
        .term_out  (t2)
      );
      wire use1 = |expr_r[g].set1_sel;
      wire use2 = |expr_r[g].set2_sel;
      // Single set passes through; both sets use a commutative join
      assign complex_res = (use1 && use2) ? (expr_r[g].inter_or ? (t1 | t2) : (t1 & t2))
                         : use1 ? t1 : use2 ? t2 : 1'b0; // RL9 RL10
      assign simple_res = (expr_r[g].simple_op == qualifier_pkg::SIMPLE_EQ)  ? s_eq
                        : (expr_r[g].simple_op == qualifier_pkg::SIMPLE_NE)  ? ~s_eq
                        : (expr_r[g].simple_op == qualifier_pkg::SIMPLE_IN)  ? s_in
                        : ~s_in; // RL2
      always_comb begin
        unique case (expr_r[g].mode)
          qualifier_pkg::QUAL_NEVER:   result_nxt[g] = 1'b0; // RL13
          qualifier_pkg::QUAL_ALWAYS:  result_nxt[g] = 1'b1; // RL13
          qualifier_pkg::QUAL_SIMPLE:  result_nxt[g] = simple_res;
          qualifier_pkg::QUAL_COMPLEX: result_nxt[g] = complex_res;
        endcase
      end
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          expr_r[g] <= '{qualifier_pkg::QUAL_NEVER, qualifier_pkg::SIMPLE_EQ,
                         `QUAL_RESET_SEL, 1'b0, 5'h00, 1'b0, 1'b0};
        end else if (expr_load_in && expr_index_in == 3'(g)) begin
          expr_r[g] <= expr_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      range_r <= '{`QUAL_RESET_VALUE, `QUAL_RESET_VALUE, `QUAL_RESET_MASK};
    end else if (range_load_in) begin
      range_r <= range_in; // RL5
    end
  end

  // Hold last result between states so consumers see a stable level
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      result_r <= '0;
      valid_r  <= 1'b0;
    end else begin
      valid_r <= state_valid_in; // RL14
      if (state_valid_in) begin
        result_r <= result_nxt; // RL14
      end
    end
  end

  assign qual_out = qualifier_pkg::qual_out_t'(result_r); // RL1
  assign qual_valid_out = valid_r;
endmodule : trace_state_qualifier

// ### qualifier_map.svh
// Constants for the trace state qualifier: widths, counts and reset values.
// Assumes inclusion by bare name from the qualifier package and modules.
`ifndef QUALIFIER_MAP_SVH
`define QUALIFIER_MAP_SVH
`define QUAL_STATE_W        32
`define QUAL_PATTERNS       8
`define QUAL_SET_PATTERNS   4
`define QUAL_RESET_SEL      6'h00
`define QUAL_RESET_MODE     2'h0
`define QUAL_RESET_VALUE    32'h0000_0000
`define QUAL_RESET_MASK     32'h0000_0000
`endif

// ### qualifier_pkg.sv
// Types for the trace state qualifier.
// Assumes qualifier_map.svh is on the include path.
`include "qualifier_map.svh"
package qualifier_pkg;
  // Expression form chosen by software for one consumer
  typedef enum logic [1:0] {
    QUAL_NEVER   = 2'b00,
    QUAL_ALWAYS  = 2'b01,
    QUAL_SIMPLE  = 2'b10,
    QUAL_COMPLEX = 2'b11
  } qual_mode_t;

  typedef enum logic [1:0] {
    SIMPLE_EQ     = 2'b00,
    SIMPLE_NE     = 2'b01,
    SIMPLE_IN     = 2'b10,
    SIMPLE_OUT    = 2'b11
  } simple_op_t;

  // One pattern term: masked label compare, optional inversion
  typedef struct packed {
    logic [`QUAL_STATE_W-1:0] value;
    logic [`QUAL_STATE_W-1:0] mask;
    logic                     invert;
  } pattern_t;

  typedef struct packed {
    logic [`QUAL_STATE_W-1:0] low;
    logic [`QUAL_STATE_W-1:0] high;
    logic [`QUAL_STATE_W-1:0] mask;
  } range_t;

  // Per-consumer expression; set1 sel: four patterns, range, inverse range
  // Set2 sel: four further patterns, then arm
  typedef struct packed {
    qual_mode_t  mode;
    simple_op_t  simple_op;
    logic [5:0]  set1_sel;
    logic        set1_nor;
    logic [4:0]  set2_sel;
    logic        set2_nor;
    logic        inter_or;
  } expr_t;

  typedef struct packed {
    logic trigger;
    logic time_qual;
    logic branch_pri;
    logic branch_sec;
    logic prestore;
  } qual_out_t;
endpackage : qualifier_pkg

// ### set_combiner.sv
// One resource set combiner: OR or NOR over selected members.
// Assumes members and selects are stable in the sampling cycle.
`timescale 1ns/1ps
module set_combiner #(
  parameter int N = 6
) (
  // Members
  input  wire logic [N-1:0] member_in,
  input  wire logic [N-1:0] select_in,
  input  wire logic         nor_in,
  // Result
  output logic              term_out
);
  wire any_hit = |(member_in & select_in);
  // One operator for all members; mixing is impossible by construction
  assign term_out = nor_in ? ~any_hit : any_hit; // RL7 RL8
endmodule : set_combiner

// ### qualifier_properties.sv
// Port checker for the trace state qualifier.
// Assumes bind onto the qualifier top module.
`timescale 1ns/1ps
module qualifier_properties (
  // Clock and state
  input wire logic                     clock_in,
  input wire logic                     rst_in,
  input wire logic [31:0]              state_in,
  input wire logic                     state_valid_in,
  // Config
  input wire logic                     expr_load_in,
  input wire logic [2:0]               expr_index_in,
  input wire qualifier_pkg::expr_t     expr_in,
  input wire logic [31:0]              simple_mask_in,
  input wire logic [31:0]              simple_low_in,
  // Results
  input wire qualifier_pkg::qual_out_t qual_out,
  input wire logic                     qual_valid_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // State with no expression load beside it
  wire logic       st  = state_valid_in && !expr_load_in;
  wire logic       hit = ((state_in ^ simple_low_in) & simple_mask_in) == 32'h0000_0000;
  wire logic [3:0] md  = {expr_in.mode, expr_in.simple_op};
  // Expression slot four lands in the trigger field, the packed struct's top bit
  wire logic       ld  = expr_load_in && expr_index_in == 3'h4;
  property p_valid; state_valid_in |=> qual_valid_out; endproperty
  a_valid: assert property (p_valid) else $error("valid lost");
  property p_idle; !state_valid_in |=> !qual_valid_out; endproperty
  a_idle: assert property (p_idle) else $error("valid spurious");
  property p_hold; !state_valid_in |=> $stable(qual_out); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_reset; $fell(rst_in) |-> qual_out == 5'h00 && !qual_valid_out; endproperty
  a_reset: assert property (p_reset) else $error("reset value");
  property p_always; ld && md[3:2] == 2'h1 ##1 st |=> qual_out.trigger; endproperty
  a_always: assert property (p_always) else $error("always false");
  property p_never; ld && md[3:2] == 2'h0 ##1 st |=> !qual_out.trigger; endproperty
  a_never: assert property (p_never) else $error("never true");
  property p_eq; expr_load_in && expr_index_in == 3'h3 && md == 4'h8 ##1 st
    |=> qual_out.time_qual == $past(hit); endproperty
  a_eq: assert property (p_eq) else $error("equal wrong");
  property p_ne; expr_load_in && expr_index_in == 3'h2 && md == 4'h9 ##1 st
    |=> qual_out.branch_pri == !$past(hit); endproperty
  a_ne: assert property (p_ne) else $error("unequal wrong");
endmodule : qualifier_properties
bind trace_state_qualifier qualifier_properties chk_u (.clock_in, .rst_in, .state_in,
  .state_valid_in, .expr_load_in, .expr_index_in, .expr_in, .simple_mask_in,
  .simple_low_in, .qual_out, .qual_valid_out);

// ### qual_sink.sv
// Trigger consumer model: counts qualified states.
// Assumes the qualifier outputs on the same clock.
`timescale 1ns/1ps
module qual_sink (
  // Analyzer side
  input wire logic                     clock_in,
  input wire logic                     rst_in,
  input wire qualifier_pkg::qual_out_t qual_in,
  input wire logic                     valid_in,
  // Count
  output int                           hits_out
);
  always_ff @(posedge clock_in) begin
    if (rst_in) hits_out <= 0;
    else if (valid_in && qual_in.trigger) hits_out <= hits_out + 1;
  end
endmodule : qual_sink

// ### tb_top.sv
// Random self-checking bench for the trace state qualifier.
// Assumes the package, the checker and qual_sink compile first.
`timescale 1ns/1ps
module tb_top;
  logic                      clock_in = 0, rst_in = 1, state_valid_in = 0, arm_in = 0;
  logic                      pattern_load_in = 0, range_load_in = 0, expr_load_in = 0;
  logic [2:0]                pattern_index_in = 0, expr_index_in = 0;
  logic [31:0]               state_in = 0, simple_mask_in = 0, simple_low_in = 0;
  logic [31:0]               simple_high_in = 0, lm = 32'h0000_0003;
  qualifier_pkg::pattern_t   pattern_in = '0, pt [8];
  qualifier_pkg::range_t     range_in = '0, rg;
  qualifier_pkg::expr_t      expr_in = '0, ex [5];
  qualifier_pkg::qual_out_t  qual_out;
  logic                      qual_valid_out;
  logic [5:0]                exp_r;
  int                        failures = 0, samples_checked = 0, hits, ref_hits;
  int                        seed = 32'h1653_25ae;
  always #12.5 clock_in = ~clock_in;
  trace_state_qualifier dut_u (.clock_in, .rst_in, .state_in, .state_valid_in, .arm_in,
    .pattern_load_in, .pattern_index_in, .pattern_in, .range_load_in, .range_in,
    .expr_load_in, .expr_index_in, .expr_in, .simple_mask_in, .simple_low_in,
    .simple_high_in, .qual_out, .qual_valid_out);
  qual_sink sink_u (.clock_in, .rst_in, .qual_in(qual_out), .valid_in(qual_valid_out),
    .hits_out(hits));
  function automatic logic ref_q(qualifier_pkg::expr_t e);
    logic [5:0]  m1;
    logic [4:0]  m2;
    logic [31:0] sm;
    logic        t1, t2;
    sm = state_in & rg.mask;
    m1[4] = rg.low <= sm && sm <= rg.high;
    m1[5] = !m1[4];
    m2[4] = arm_in;
    for (int i = 0; i < 4; i++) begin
      m1[i] = (((state_in ^ pt[i].value) & pt[i].mask) == 0) ^ pt[i].invert;
      m2[i] = (((state_in ^ pt[i+4].value) & pt[i+4].mask) == 0) ^ pt[i+4].invert;
    end
    t1 = e.set1_nor ^ |(m1 & e.set1_sel);
    t2 = e.set2_nor ^ |(m2 & e.set2_sel);
    sm = state_in & simple_mask_in;
    case (e.mode)
      2'h1: return 1'b1;
      2'h2: return e.simple_op[0] ^ (e.simple_op[1] ? simple_low_in <= sm &&
        sm <= simple_high_in : sm == (simple_low_in & simple_mask_in));
      2'h3: if (|e.set1_sel && |e.set2_sel) return e.inter_or ? t1 | t2 : t1 & t2;
        else return |e.set1_sel ? t1 : |e.set2_sel && t2;
      default: return 1'b0;
    endcase
  endfunction : ref_q
  task automatic chk_q(logic [5:0] got, logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t result %h exp %h", $time, got, exp);
    end
  endtask : chk_q
  task automatic chk_n(int got, int exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t hits %0d exp %0d", $time, got, exp);
    end
  endtask : chk_n
  task automatic test_done;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Model sees pre-edge inputs, so a state uses the old config
  always @(posedge clock_in) begin
    if (rst_in) begin
      exp_r = 0;
      ref_hits = 0;
      rg = '0;
      foreach (pt[i]) pt[i] = '0;
      foreach (ex[i]) ex[i] = '0;
    end else begin
      chk_q({qual_valid_out, qual_out}, exp_r);
      if (exp_r[5] && exp_r[4]) ref_hits++;
      exp_r[5] = state_valid_in;
      // Slot i drives result bit i; slot four is the trigger
      if (state_valid_in) for (int i = 0; i < 5; i++) exp_r[i] = ref_q(ex[i]);
      if (pattern_load_in) pt[pattern_index_in] = pattern_in;
      if (range_load_in) rg = range_in;
      if (expr_load_in && expr_index_in < 5) ex[expr_index_in] = expr_in;
    end
  end
  // Two-bit states keep matches frequent; expr format allows one term per set
  initial begin
    repeat (6) @(posedge clock_in);
    for (int n = 0; n < 8000; n++) begin
      rst_in <= n >= 4000 && n < 4003;
      {state_valid_in, arm_in, pattern_load_in, range_load_in} <= 4'($random(seed));
      {expr_load_in, pattern_index_in, expr_index_in} <= 7'($random(seed));
      state_in <= $random(seed) & lm;
      simple_mask_in <= $random(seed);
      simple_low_in <= $random(seed) & lm;
      simple_high_in <= $random(seed) & lm;
      pattern_in <= {$random(seed) & lm, $random(seed), 1'($random(seed))};
      range_in <= {$random(seed) & lm, $random(seed) & lm, $random(seed)};
      expr_in <= 18'($random(seed));
      @(posedge clock_in);
    end
    state_valid_in <= 0;
    repeat (3) @(posedge clock_in);
    chk_n(hits, ref_hits);
    test_done;
  end
  initial begin
    #400000;
    failures++;
    test_done;
  end
endmodule : tb_top
